// ===== core/frm_pkg.sv
// package: constants of the fault response monitor
package frm_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_SENS_EN   = 8'h04;
  localparam logic [7:0] REG_EXC_STAT  = 8'h08;
  localparam logic [7:0] REG_EXC_MASK  = 8'h0C;
  localparam logic [7:0] REG_RST_CAUSE = 8'h10;
  localparam logic [7:0] REG_HV_STAT   = 8'h14;
  localparam logic [7:0] REG_SP_LIM0   = 8'h18;
  localparam logic [7:0] REG_SP_VAL0   = 8'h24;
  localparam logic [7:0] REG_ECC_DATA  = 8'h30;
  localparam logic [7:0] REG_STEP      = 8'h04;
  // control fields
  localparam int CTRL_INV_ECC = 0;
  localparam int CTRL_LSEL_LO = 1;
  localparam logic [1:0] LSEL_OFF = 2'h0;
  localparam logic [1:0] LSEL_A   = 2'h1;
  localparam logic [1:0] LSEL_B   = 2'h2;
  // sensors: voltage, frequency, temperature, light
  localparam int          NUM_SENS     = 4;
  localparam logic [3:0]  SENS_ALL_ON  = 4'hF;
  // exception status bits
  localparam int NUM_EXC     = 4;
  localparam int EXC_EE_LGT  = 0;
  localparam int EXC_FAULT   = 1;
  localparam int EXC_ECC     = 2;
  localparam int EXC_STACK   = 3;
  // reset cause bits, low four follow the sensor order
  localparam int NUM_CAUSE    = 7;
  localparam int CAUSE_FETCH  = 4;
  localparam int CAUSE_MMU    = 5;
  localparam int CAUSE_ROMPAR = 6;
  // other single-fault detectors
  localparam int NUM_DET = 4;
  // stack pointers: user, system, super-system
  localparam int          NUM_SP  = 3;
  localparam int          SP_W    = 16;
  localparam logic [1:0]  MODE_USR = 2'h0;
  localparam logic [1:0]  MODE_SYS = 2'h1;
  localparam logic [1:0]  MODE_SSM = 2'h2;
  localparam logic [SP_W-1:0] SP_LIM_RST = 16'hFFFF;
  // forced reset pulse width
  localparam int CLK_PERIOD_NS = 8;
  localparam int RST_PULSE_NS  = 128;
  localparam int RST_CYC       = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] RST_CYC_W = 5'(RST_CYC);
endpackage

// ===== core/frm_monitor.sv
// fault response monitor: alarm routing to chip reset or exception
//
// Behaviour
// - voltage, frequency, temperature or light sensor alarm forces a chip reset
// - protected-fetch or address-cache single-fault alarm forces a chip reset
// - eeprom light detector or other fault detectors raise an exception
// - with inverse ecc enabled, any detected eeprom error raises an exception
// - forced reset reinitialises everything and leaves a readable reset cause
// - every exception leaves an indication of its source
// - reset aborts the program; exception interrupts it for software
// - outside test mode all sensors are enabled; disable writes ignored
// - routing of each alarm is hard-wired, never software writable
// - three stack pointers with own limits; exceeding active limit raises exception
// - eeprom high-voltage check only readable, never raises an event
// - two eeprom light functions; software selects one or disables both
// - eeprom read path corrects any single-bit error per byte automatically
// - rom parity error forces a chip reset
`timescale 1ns/1ps
module frm_monitor
  import frm_pkg::*;
(
  // clock and power-on reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata,
  // environmental sensors and mode
  input  wire logic [NUM_SENS-1:0] sens_alarm,
  input  wire logic                test_mode,
  output logic      [NUM_SENS-1:0] sens_enable,
  // fault injection detectors
  input  wire logic                fetch_fault,
  input  wire logic                mmu_fault,
  input  wire logic [NUM_DET-1:0]  det_fault,
  input  wire logic                ee_light_a,
  input  wire logic                ee_light_b,
  // memory checks
  input  wire logic                ee_rd_valid,
  input  wire logic [11:0]         ee_rd_code,
  output logic      [7:0]          ee_rd_data,
  output logic                     ee_rd_data_valid,
  input  wire logic                rom_rd_valid,
  input  wire logic [7:0]          rom_rd_data,
  input  wire logic                rom_rd_par,
  input  wire logic                hv_check_done,
  input  wire logic                hv_check_ok,
  // stack pointers
  input  wire logic [1:0]          cpu_mode,
  input  wire logic                sp_wr,
  input  wire logic [SP_W-1:0]     sp_wdata,
  output logic      [SP_W-1:0]     sp_active,
  // responses
  output logic                     chip_rst,
  output logic                     exc_irq
);

  // hamming(12,8) single-error correction; returns {error, byte}
  function automatic logic [8:0] ecc_fix(input logic [11:0] c);
    logic [3:0]  syn;
    logic [11:0] f;
    syn = 4'h0;
    for (int p = 1; p <= 12; p++) begin
      for (int b = 0; b < 4; b++) begin
        if (p[b]) begin
          syn[b] = syn[b] ^ c[p-1];
        end
      end
    end
    f = c;
    if (syn != 4'h0 && syn <= 4'hC) begin
      f[syn-4'h1] = ~c[syn-4'h1];
    end
    return {(syn != 4'h0), f[11], f[10], f[9], f[8], f[6], f[5], f[4], f[2]};
  endfunction

  // register address decode shared by several registers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  logic [2:0]          ctrl_q;
  logic [NUM_SENS-1:0] sens_sw_q;
  logic [NUM_EXC-1:0]  exc_stat_q;
  logic [NUM_EXC-1:0]  exc_mask_q;
  logic [NUM_CAUSE-1:0] cause_q;
  logic [1:0]          hv_q;
  logic [SP_W-1:0]     sp_q  [NUM_SP];
  logic [SP_W-1:0]     lim_q [NUM_SP];
  logic [4:0]          rst_cnt_q;
  logic [7:0]          ee_data_q;
  logic                ee_vld_q;
  logic [31:0]         rdata_q;

  logic                inv_ecc;
  logic [1:0]          lsel;
  logic [NUM_CAUSE-1:0] cause_set;
  logic [NUM_EXC-1:0]  exc_set;
  logic [8:0]          ecc_res;
  logic                rom_par_err;
  logic                light_evt;
  logic [1:0]          sp_idx;
  logic                sp_over;

  assign inv_ecc = ctrl_q[CTRL_INV_ECC];
  assign lsel    = ctrl_q[CTRL_LSEL_LO +: 2];

  // sensors forced on outside test mode
  assign sens_enable = test_mode ? sens_sw_q : SENS_ALL_ON;

  // inverse option stores complemented code words
  assign ecc_res = ecc_fix(inv_ecc ? ~ee_rd_code : ee_rd_code);

  assign rom_par_err = rom_rd_valid && ((^rom_rd_data) != rom_rd_par);

  // light function chosen by software, none when off
  always_comb begin
    case (lsel)
      LSEL_A:  light_evt = ee_light_a;
      LSEL_B:  light_evt = ee_light_b;
      default: light_evt = 1'b0;
    endcase
  end

  // super-system mode covers boot, test and the contactless mode
  assign sp_idx    = (cpu_mode == MODE_USR) ? MODE_USR : (cpu_mode == MODE_SYS) ? MODE_SYS : MODE_SSM;
  assign sp_active = sp_q[sp_idx];
  assign sp_over   = sp_q[sp_idx] > lim_q[sp_idx];

  // hard-wired routing; only the test-mode sensor enable register reaches these terms
  assign cause_set = {rom_par_err, mmu_fault, fetch_fault, sens_alarm & sens_enable};

  always_comb begin
    exc_set             = '0;
    exc_set[EXC_EE_LGT] = light_evt;
    exc_set[EXC_FAULT]  = |det_fault;
    exc_set[EXC_ECC]    = inv_ecc && ee_rd_valid && ecc_res[8];
    exc_set[EXC_STACK]  = sp_over;
  end

  // forced reset pulse; stretched so every block sees it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rst_cnt_q <= 5'h00;
    end else if (|cause_set) begin
      rst_cnt_q <= RST_CYC_W;
    end else if (rst_cnt_q != 5'h00) begin
      rst_cnt_q <= rst_cnt_q - 5'h01;
    end
  end
  assign chip_rst = rst_cnt_q != 5'h00;

  // cause bits only see power-on reset, not chip_rst; set wins over clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cause_q <= '0;
    end else if (reg_wr && hit(reg_addr, REG_RST_CAUSE)) begin
      cause_q <= (cause_q & ~reg_wdata[NUM_CAUSE-1:0]) | cause_set;
    end else begin
      cause_q <= cause_q | cause_set;
    end
  end

  // exception status: sticky, read clears, new events kept
  always_ff @(posedge sys_clk) begin
    if (rst || chip_rst) begin
      exc_stat_q <= '0;
    end else if (reg_rd && hit(reg_addr, REG_EXC_STAT)) begin
      exc_stat_q <= exc_set;
    end else begin
      exc_stat_q <= exc_stat_q | exc_set;
    end
  end
  assign exc_irq = |(exc_stat_q & exc_mask_q);

  // software control registers, reinitialised by forced reset too
  always_ff @(posedge sys_clk) begin
    if (rst || chip_rst) begin
      ctrl_q     <= 3'h0;
      exc_mask_q <= '0;
      sens_sw_q  <= SENS_ALL_ON;
    end else if (reg_wr) begin
      if (hit(reg_addr, REG_CTRL)) begin
        ctrl_q <= reg_wdata[2:0];
      end
      if (hit(reg_addr, REG_EXC_MASK)) begin
        exc_mask_q <= reg_wdata[NUM_EXC-1:0];
      end
      // only test mode may switch a sensor off
      if (hit(reg_addr, REG_SENS_EN) && test_mode) begin
        sens_sw_q <= reg_wdata[NUM_SENS-1:0];
      end
    end
  end

  // stack pointers and limits
  always_ff @(posedge sys_clk) begin
    if (rst || chip_rst) begin
      for (int i = 0; i < NUM_SP; i++) begin
        sp_q[i]  <= '0;
        lim_q[i] <= SP_LIM_RST;
      end
    end else begin
      if (sp_wr) begin
        sp_q[sp_idx] <= sp_wdata;
      end
      for (int i = 0; i < NUM_SP; i++) begin
        if (reg_wr && hit(reg_addr, REG_SP_LIM0 + 8'(i) * REG_STEP)) begin
          lim_q[i] <= reg_wdata[SP_W-1:0];
        end
      end
    end
  end

  // high-voltage result: readable only, no event path
  always_ff @(posedge sys_clk) begin
    if (rst || chip_rst) begin
      hv_q <= 2'h0;
    end else if (hv_check_done) begin
      hv_q <= {1'b1, hv_check_ok};
    end
  end

  // corrected eeprom byte, no software step involved
  always_ff @(posedge sys_clk) begin
    if (rst || chip_rst) begin
      ee_data_q <= 8'h00;
      ee_vld_q  <= 1'b0;
    end else begin
      ee_vld_q <= ee_rd_valid;
      if (ee_rd_valid) begin
        ee_data_q <= ecc_res[7:0];
      end
    end
  end
  assign ee_rd_data       = ee_data_q;
  assign ee_rd_data_valid = ee_vld_q;

  // read data registered; unmapped reads give zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_q <= 32'h0000_0000;
      case (reg_addr)
        REG_CTRL:      rdata_q[2:0]           <= ctrl_q;
        REG_SENS_EN:   rdata_q[NUM_SENS-1:0]  <= sens_enable;
        REG_EXC_STAT:  rdata_q[NUM_EXC-1:0]   <= exc_stat_q;
        REG_EXC_MASK:  rdata_q[NUM_EXC-1:0]   <= exc_mask_q;
        REG_RST_CAUSE: rdata_q[NUM_CAUSE-1:0] <= cause_q;
        REG_HV_STAT:   rdata_q[1:0]           <= hv_q;
        REG_ECC_DATA:  rdata_q[7:0]           <= ee_data_q;
        default: begin
          for (int i = 0; i < NUM_SP; i++) begin
            if (reg_addr == REG_SP_LIM0 + 8'(i) * REG_STEP) begin
              rdata_q[SP_W-1:0] <= lim_q[i];
            end
            if (reg_addr == REG_SP_VAL0 + 8'(i) * REG_STEP) begin
              rdata_q[SP_W-1:0] <= sp_q[i];
            end
          end
        end
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_q;

  // checks
  a_sens_alarm_reset: assert property (@(posedge sys_clk) disable iff (rst)
    (|(sens_alarm & sens_enable)) |=> chip_rst && (rst_cnt_q == RST_CYC_W))
    else $error("sensor alarm did not force reset");

  a_fetch_mmu_reset: assert property (@(posedge sys_clk) disable iff (rst)
    (fetch_fault || mmu_fault) |=> chip_rst && (cause_q[CAUSE_FETCH] || !$past(fetch_fault))
      && (cause_q[CAUSE_MMU] || !$past(mmu_fault)))
    else $error("fetch or cache fault did not force reset");

  // antecedent built from pins so a wrong route into the reset path trips it
  a_fault_exc_only: assert property (@(posedge sys_clk) disable iff (rst)
    ((|det_fault || light_evt) && !fetch_fault && !mmu_fault && !rom_par_err
      && !(|(sens_alarm & sens_enable)) && !chip_rst)
    |=> !chip_rst && (exc_stat_q[EXC_FAULT] || !$past(|det_fault))
      && (exc_stat_q[EXC_EE_LGT] || !$past(light_evt)))
    else $error("fault detector did not raise exception");

  a_ecc_exception: assert property (@(posedge sys_clk) disable iff (rst || chip_rst)
    (inv_ecc && ee_rd_valid && ecc_res[8] && !(|cause_set)) |=> exc_stat_q[EXC_ECC])
    else $error("ecc error not raised as exception");

  a_reset_width: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(chip_rst) |-> (rst_cnt_q == RST_CYC_W) ##1 chip_rst [*8] ##1 chip_rst [*7])
    else $error("forced reset pulse width wrong");

  a_sens_forced_on: assert property (@(posedge sys_clk) disable iff (rst)
    !test_mode |-> sens_enable == SENS_ALL_ON)
    else $error("sensor disabled outside test mode");

  a_stack_limit: assert property (@(posedge sys_clk) disable iff (rst || chip_rst)
    (sp_active > lim_q[sp_idx] && !(|cause_set)) |=> exc_stat_q[EXC_STACK])
    else $error("stack limit overrun missed");

  a_cause_survives: assert property (@(posedge sys_clk) disable iff (rst)
    (cause_q != '0 && !(reg_wr && reg_addr == REG_RST_CAUSE)) |=> ((cause_q & $past(cause_q)) == $past(cause_q)))
    else $error("reset cause lost without clear");

  a_rom_parity_rst: assert property (@(posedge sys_clk) disable iff (rst)
    rom_par_err |=> chip_rst && cause_q[CAUSE_ROMPAR])
    else $error("rom parity error did not reset");

endmodule

// ===== testbench/frm_ee_model.sv
// eeprom code word source: hamming(12,8) encoder with single-bit injection
`timescale 1ns/1ps
module frm_ee_model
  import frm_pkg::*;
(
  // stored byte and injected fault
  input  wire logic [7:0]  ee_byte,
  input  wire logic [3:0]  flip_pos,
  input  wire logic        inv_en,
  // code word toward the monitor
  output logic      [11:0] ee_code
);
  int          p;
  int          i;
  int          j;
  logic [11:0] c;
  always_comb begin
    c = 12'h000;
    j = 0;
    for (p = 1; p <= 12; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p-1] = ee_byte[j];
        j++;
      end
    end
    for (i = 0; i < 4; i++) begin
      for (p = 1; p <= 12; p++) begin
        if (p[i] && p != (1 << i)) c[(1<<i)-1] ^= c[p-1];
      end
    end
    // position 0 means a clean word
    if (flip_pos != 4'h0) c[flip_pos-1] = ~c[flip_pos-1];
    ee_code = inv_en ? ~c : c;
  end
endmodule

// ===== testbench/frm_monitor_bench.sv
// self-checking bench of the fault response monitor
`timescale 1ns/1ps
module frm_monitor_bench import frm_pkg::*;;
  logic        sys_clk = 1'h0;
  logic        rst = 1'h1;
  logic        reg_wr, reg_rd, test_mode, fetch_fault, mmu_fault, ee_light_a, ee_light_b;
  logic        ee_rd_valid, rom_rd_valid, rom_rd_par, hv_check_done, hv_check_ok, sp_wr, inv_en;
  logic        chip_rst, exc_irq, ee_rd_data_valid;
  logic [7:0]  reg_addr, rom_rd_data, ee_byte, ee_rd_data;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0]  sens_alarm, det_fault, flip_pos, sens_enable;
  logic [1:0]  cpu_mode;
  logic [15:0] sp_wdata, sp_active;
  logic [11:0] ee_rd_code;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n;

  frm_monitor DUT (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sens_alarm,
    .test_mode, .sens_enable, .fetch_fault, .mmu_fault, .det_fault, .ee_light_a, .ee_light_b,
    .ee_rd_valid, .ee_rd_code, .ee_rd_data, .ee_rd_data_valid, .rom_rd_valid, .rom_rd_data,
    .rom_rd_par, .hv_check_done, .hv_check_ok, .cpu_mode, .sp_wr, .sp_wdata, .sp_active,
    .chip_rst, .exc_irq);
  frm_ee_model ee (.ee_byte, .flip_pos, .inv_en, .ee_code(ee_rd_code));

  always #4 sys_clk = ~sys_clk;

  task automatic close_out();
    $display("mismatches %0d of %0d compared", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // hang guard, run needs under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
    @(posedge sys_clk) reg_wr <= 1'h0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge sys_clk) {reg_rd, reg_addr} <= {1'h1, a};
    @(posedge sys_clk) reg_rd <= 1'h0;
    #1 chk(nm, e, reg_rdata);
  endtask
  task automatic hit(input int k, input logic v);
    @(posedge sys_clk);
    case (k)
      0, 1, 2, 3: sens_alarm[k] <= v;
      4: fetch_fault <= v;
      5: mmu_fault <= v;
      6: {rom_rd_valid, rom_rd_par} <= {v, v};
      7: ee_light_a <= v;
      8: ee_light_b <= v;
      9: hv_check_done <= v;
      default: det_fault[k-10] <= v;
    endcase
  endtask
  // one-cycle event, outputs looked at just after the edge that took it
  task automatic fire(input int k);
    hit(k, 1'h1);
    hit(k, 1'h0);
    #1;
  endtask
  task automatic exc(input int k, input logic [31:0] e);
    fire(k);
    chk("exc_irq", 32'(e != 0), exc_irq);
    chk("no_reset", 32'h0, chip_rst);
    rd(REG_EXC_STAT, e, "exc_stat");
    rd(REG_EXC_STAT, 32'h0, "exc_stat_clr");
    chk("irq_clr", 32'h0, exc_irq);
  endtask
  task automatic ecc(input logic [7:0] b, input int f, input logic [31:0] e);
    @(posedge sys_clk) {ee_byte, flip_pos, ee_rd_valid} <= {b, 4'(f), 1'h1};
    @(posedge sys_clk) ee_rd_valid <= 1'h0;
    #1 chk("ee_data", b, ee_rd_data);
    chk("ee_valid", 32'h1, ee_rd_data_valid);
    rd(REG_EXC_STAT, e, "ecc_stat");
    chk("ee_valid_end", 32'h0, ee_rd_data_valid);
  endtask
  task automatic spw(input logic [15:0] v, input logic [31:0] e);
    @(posedge sys_clk) {sp_wr, sp_wdata} <= {1'h1, v};
    @(posedge sys_clk) sp_wr <= 1'h0;
    #1 chk("sp_active", v, sp_active);
    rd(REG_EXC_STAT, e, "sp_stat");
  endtask

  initial begin
    {reg_wr, reg_rd, test_mode, fetch_fault, mmu_fault, ee_light_a, ee_light_b, ee_rd_valid} = 8'h00;
    {rom_rd_valid, rom_rd_par, hv_check_done, hv_check_ok, sp_wr, inv_en} = 6'h00;
    {reg_addr, reg_wdata, sens_alarm, det_fault, flip_pos, cpu_mode, sp_wdata} = 70'h0;
    {rom_rd_data, ee_byte} = 16'h3C00;
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    wr(8'hFC, 32'hFFFFFFFF);
    rd(8'hFC, 32'h0, "unmapped");
    rd(REG_CTRL, 32'h0, "ctrl_rst");
    rd(REG_SP_LIM0, 32'hFFFF, "sp_lim_rst");
    chk("sens_en", SENS_ALL_ON, sens_enable);
    wr(REG_SENS_EN, 32'h0);
    rd(REG_SENS_EN, SENS_ALL_ON, "sens_en_locked");
    @(posedge sys_clk) test_mode <= 1'h1;
    wr(REG_SENS_EN, 32'h5);
    fire(1);
    chk("sens_en_test", 32'h5, sens_enable);
    chk("disabled_sensor", 32'h0, chip_rst);
    @(posedge sys_clk) test_mode <= 1'h0;
    tick();
    chk("sens_en_back", SENS_ALL_ON, sens_enable);
    for (int k = 0; k < 7; k++) begin
      wr(REG_EXC_MASK, 32'hF);
      wr(REG_CTRL, 32'h7);
      fire(k);
      n = 0;
      repeat (40) begin
        if (chip_rst === 1'h1) n++;
        tick();
      end
      chk("reset_cycles", RST_CYC, n);
      rd(REG_RST_CAUSE, 32'h1 << k, "cause");
      rd(REG_EXC_MASK, 32'h0, "mask_reinit");
      rd(REG_CTRL, 32'h0, "ctrl_reinit");
      wr(REG_RST_CAUSE, 32'h7F);
      rd(REG_RST_CAUSE, 32'h0, "cause_clr");
    end
    wr(REG_EXC_MASK, 32'hF);
    for (int s = 0; s < 4; s++) begin
      wr(REG_CTRL, 32'(s << 1));
      exc(7, 32'(s == 1));
      exc(8, 32'(s == 2));
    end
    for (int j = 0; j < 4; j++) exc(10 + j, 32'h2);
    for (int v = 0; v < 2; v++) begin
      @(posedge sys_clk) hv_check_ok <= v[0];
      exc(9, 32'h0);
      rd(REG_HV_STAT, 32'(2 + v), "hv_stat");
    end
    wr(REG_EXC_MASK, 32'h0);
    fire(11);
    chk("irq_masked", 32'h0, exc_irq);
    rd(REG_EXC_STAT, 32'h2, "stat_masked");
    wr(REG_EXC_MASK, 32'hF);
    for (int f = 0; f <= 12; f++) ecc(8'hA5 ^ 8'(f), f, 32'h0);
    wr(REG_CTRL, 32'h1);
    @(posedge sys_clk) inv_en <= 1'h1;
    for (int f = 0; f <= 12; f++) ecc(8'h5A, f, (f != 0) ? 32'h4 : 32'h0);
    rd(REG_ECC_DATA, 32'h5A, "ecc_last");
    // mode 3 shares the super-system pointer; its limit write lands on a read-only slot
    for (int m = 0; m < 4; m++) begin
      @(posedge sys_clk) cpu_mode <= 2'(m);
      wr(REG_SP_LIM0 + 8'(4 * m), 32'h100);
      spw(16'h0100, 32'h0);
      spw(16'h0101, 32'h8);
      rd(REG_SP_VAL0 + 8'(4 * ((m < 2) ? m : 2)), 32'h101, "sp_val");
      spw(16'h0000, 32'h8);
      rd(REG_EXC_STAT, 32'h0, "sp_clr");
    end
    rd(REG_SP_VAL0, 32'h0, "sp_val_ro");
    fire(4);
    repeat (20) tick();
    @(posedge sys_clk) rst <= 1'h1;
    @(posedge sys_clk) rst <= 1'h0;
    rd(REG_RST_CAUSE, 32'h0, "cause_por");
    close_out();
  end
endmodule
